// ---- async_sram_access_port_bench.sv ----
/* Self-checking bench for sram_host beside a behavioural RAM.
   Assumes the power-up and cycle counts of the shared header. */
`timescale 1ns/1ps
`include "sram_host_map.vh"
module async_sram_access_port_bench;
  reg         mclk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, write_i = 1'b0;
  reg  [16:0] addr_i = 17'h00000;
  reg  [7:0]  wdata_i = 8'h00;
  wire        ready_o, done_o, select_low_active_n_o, select_high_active_o;
  wire        out_enable_n_o, write_strobe_n_o, data_lines_oe_o;
  wire [7:0]  rdata_o, data_lines_i, data_lines_o;
  wire [16:0] address_lines_o;
  integer     num_errors = 0, n_checks = 0, i, k;
  reg  [31:0] r;
  reg  [7:0]  exp_q [0:31];
  reg  [16:0] adr [0:31];
  always #50 mclk_i = ~mclk_i;
  sram_host i_sram_host (.*);
  sram_model i_sram_model (.addr_i(address_lines_o),
    .sel_n_i(select_low_active_n_o), .sel_i(select_high_active_o),
    .oe_n_i(out_enable_n_o), .we_n_i(write_strobe_n_o),
    .hd_i(data_lines_o), .hoe_i(data_lines_oe_o), .dq_o(data_lines_i));
  task chk(input [31:0] got, input [31:0] exp); begin
    n_checks = n_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  end endtask
  // edges from the take to done_o: a write selects, opens, closes and
  // ends; a read captures after its read time and then ends
  function integer exp_lat(input w);
    exp_lat = w ? `STROBE_CYC + 3 : `READ_CYC + 1;
  endfunction
  // a wait that runs out counts as a mismatch and ends the tests
  task give_up(input [31:0] lim); begin
    num_errors = num_errors + 1;
    $display("[FAIL] %0t wait of %0d cycles ran out", $time, lim);
    disable tests;
  end endtask
  task conclude; begin
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  // one request; start is held an extra busy cycle, which must be ignored
  task access(input w, input [16:0] ad, input [7:0] d, output integer lat);
    integer n;
  begin
    for (n = 0; ready_o !== 1'b1 && n < 50; n = n + 1) @(negedge mclk_i);
    if (ready_o !== 1'b1) give_up(50);
    start_i = 1'b1;
    write_i = w;
    addr_i = ad;
    wdata_i = d;
    @(negedge mclk_i);
    @(negedge mclk_i);
    start_i = 1'b0;
    for (lat = 1; done_o !== 1'b1 && lat < 20; lat = lat + 1)
      @(negedge mclk_i);
    if (done_o !== 1'b1) give_up(20);
  end endtask
  initial begin
    r = $urandom(32'h10C0);
    begin : tests
      repeat (16) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (`POWER_UP_CYC / 2) @(negedge mclk_i);
      // a request inside the wait must be ignored
      start_i = 1'b1;
      @(negedge mclk_i);
      start_i = 1'b0;
      chk(select_low_active_n_o, 1'b1);
      chk(ready_o, 1'b0);
      for (i = `POWER_UP_CYC / 2 + 1;
           ready_o !== 1'b1 && i < `POWER_UP_CYC + 100; i = i + 1)
        @(negedge mclk_i);
      chk(i, `POWER_UP_CYC);
      $display("test power-up done");
      for (i = 0; i < 32; i = i + 1) begin
        r = $urandom;
        adr[i] = {i[4:0], i == 0 ? 12'h000 : i == 31 ? 12'hFFF : r[11:0]};
        exp_q[i] = r[23:16];
        access(1'b1, adr[i], exp_q[i], k);
        chk(k, exp_lat(1'b1));
      end
      for (i = 31; i >= 0; i = i - 1) begin
        access(1'b0, adr[i], 8'hA5, k);
        chk(k, exp_lat(1'b0));
        chk(rdata_o, exp_q[i]);
      end
      $display("test traffic done");
    end
    conclude;
  end
endmodule

// ---- sram_host.v ----
/*
  Host-side controller for an asynchronous 128K x 8 static RAM. Takes one
  read or write request at a time on a start/done handshake and drives the
  RAM's selects, strobes, address and two-way data lines.
  Assumes a 10 MHz clock, request inputs synchronous to it, and that the
  RAM supply is at its typical level when reset is released.
*/
`timescale 1ns/1ps
`include "sram_host_map.vh"

module sram_host (
  input  wire               mclk_i,
  input  wire               rst_i,
  input  wire               start_i,
  input  wire               write_i,
  input  wire [`ADDR_W-1:0] addr_i,
  input  wire [`DATA_W-1:0] wdata_i,
  output reg                ready_o,
  output reg                done_o,
  output reg  [`DATA_W-1:0] rdata_o,
  output reg  [`ADDR_W-1:0] address_lines_o,
  output reg                select_low_active_n_o,
  output reg                select_high_active_o,
  output reg                out_enable_n_o,
  output reg                write_strobe_n_o,
  input  wire [`DATA_W-1:0] data_lines_i,
  output reg  [`DATA_W-1:0] data_lines_o,
  output reg                data_lines_oe_o
);

  // ***************************************************
  // states
  // ***************************************************
  localparam [2:0] ST_POWER  = 3'h0;
  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_WSEL   = 3'h2;
  localparam [2:0] ST_WSTRB  = 3'h3;
  localparam [2:0] ST_WEND   = 3'h4;
  localparam [2:0] ST_RSEL   = 3'h5;
  localparam [2:0] ST_RDONE  = 3'h6;

  // ***************************************************
  // state and next values
  // ***************************************************
  reg [2:0]         state_q;
  reg [2:0]         state_d;
  reg [`CNT_W-1:0]  cnt_q;
  reg [`CNT_W-1:0]  cnt_d;
  reg               ready_d;
  reg               done_d;
  reg [`DATA_W-1:0] rdata_d;
  reg [`ADDR_W-1:0] addr_d;
  reg               sel_n_d;
  reg               sel_d;
  reg               oe_n_d;
  reg               we_n_d;
  reg [`DATA_W-1:0] dout_d;
  reg               doe_d;

  // ***************************************************
  // counter helpers
  // ***************************************************
  // count value on the last period of an interval of n periods
  function [`CNT_W-1:0] load_cnt;
    input integer n;
    begin
      load_cnt = n[`CNT_W-1:0] - `CNT_ONE;
    end
  endfunction

  // true on the last period, so an interval is n whole periods
  function cnt_hit;
    input [`CNT_W-1:0] cnt;
    input integer      n;
    begin
      cnt_hit = (cnt == load_cnt(n));
    end
  endfunction

  // one period on, kept to the counter width
  function [`CNT_W-1:0] cnt_step;
    input [`CNT_W-1:0] cnt;
    begin
      cnt_step = cnt + `CNT_ONE;
    end
  endfunction

  // ***************************************************
  // sequencer, next values
  // ***************************************************
  // write: selects first with the strobe high, strobe low one edge later
  // with data already driven, strobe rises alone to end the write, then
  // deselect. output enable stays high so the RAM never drives in a write.
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ready_d = ready_o;
    done_d  = 1'b0;
    rdata_d = rdata_o;
    addr_d  = address_lines_o;
    sel_n_d = select_low_active_n_o;
    sel_d   = select_high_active_o;
    oe_n_d  = out_enable_n_o;
    we_n_d  = write_strobe_n_o;
    dout_d  = data_lines_o;
    doe_d   = data_lines_oe_o;
    case (state_q)
      ST_POWER: begin
        // RAM stays deselected until the supply has settled
        if (cnt_hit(cnt_q, `POWER_UP_CYC)) begin
          state_d = ST_IDLE;
          cnt_d   = `CNT_ZERO;
          ready_d = 1'b1;
        end else begin
          cnt_d = cnt_step(cnt_q);
        end
      end
      ST_IDLE: begin
        if (start_i) begin
          ready_d = 1'b0;
          addr_d  = addr_i;
          we_n_d  = 1'b1;
          oe_n_d  = 1'b1;
          cnt_d   = `CNT_ZERO;
          if (write_i) begin
            // drive only while outputs are disabled, selects not yet on
            dout_d  = wdata_i;
            doe_d   = 1'b1;
            state_d = ST_WSEL;
          end else begin
            // address and selects on the same edge: address not later
            sel_n_d = 1'b0;
            sel_d   = 1'b1;
            oe_n_d  = 1'b0;
            state_d = ST_RSEL;
          end
        end
      end
      ST_WSEL: begin
        // selects on with the strobe still high; outputs held off by oe
        sel_n_d = 1'b0;
        sel_d   = 1'b1;
        state_d = ST_WSTRB;
      end
      ST_WSTRB: begin
        if (write_strobe_n_o) begin
          // open the pulse one edge after the selects settled
          we_n_d = 1'b0;
        end else if (cnt_hit(cnt_q, `STROBE_CYC)) begin
          // strobe alone ends the write; data held past that edge
          we_n_d  = 1'b1;
          cnt_d   = `CNT_ZERO;
          state_d = ST_WEND;
        end else begin
          cnt_d = cnt_step(cnt_q);
        end
      end
      ST_WEND: begin
        // deselect one edge after the strobe, never on the same edge
        sel_n_d = 1'b1;
        sel_d   = 1'b0;
        doe_d   = 1'b0;
        done_d  = 1'b1;
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_RSEL: begin
        if (cnt_hit(cnt_q, `READ_CYC)) begin
          rdata_d = data_lines_i;
          state_d = ST_RDONE;
        end else begin
          cnt_d = cnt_step(cnt_q);
        end
      end
      ST_RDONE: begin
        // release outputs; a following write still waits one idle edge
        sel_n_d = 1'b1;
        sel_d   = 1'b0;
        oe_n_d  = 1'b1;
        done_d  = 1'b1;
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ***************************************************
  // registers
  // ***************************************************
  // every RAM pin comes from a flip-flop so no decode glitch reaches it
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q               <= ST_POWER;
      cnt_q                 <= `CNT_ZERO;
      ready_o               <= 1'b0;
      done_o                <= 1'b0;
      rdata_o               <= `DATA_RST;
      address_lines_o       <= `ADDR_RST;
      select_low_active_n_o <= 1'b1;
      select_high_active_o  <= 1'b0;
      out_enable_n_o        <= 1'b1;
      write_strobe_n_o      <= 1'b1;
      data_lines_o          <= `DATA_RST;
      data_lines_oe_o       <= 1'b0;
    end else begin
      state_q               <= state_d;
      cnt_q                 <= cnt_d;
      ready_o               <= ready_d;
      done_o                <= done_d;
      rdata_o               <= rdata_d;
      address_lines_o       <= addr_d;
      select_low_active_n_o <= sel_n_d;
      select_high_active_o  <= sel_d;
      out_enable_n_o        <= oe_n_d;
      write_strobe_n_o      <= we_n_d;
      data_lines_o          <= dout_d;
      data_lines_oe_o       <= doe_d;
    end
  end

endmodule

// ---- sram_host_chk.sv ----
/* Pin checker for sram_host, bound at the foot of this file.
   Assumes the header widths and the 1000-cycle power-up wait. */
`timescale 1ns/1ps
`include "sram_host_map.vh"
module sram_host_chk (
  input wire               mclk_i,
  input wire               rst_i,
  input wire [`ADDR_W-1:0] address_lines_o,
  input wire               select_low_active_n_o,
  input wire               select_high_active_o,
  input wire               out_enable_n_o,
  input wire               write_strobe_n_o,
  input wire [`DATA_W-1:0] data_lines_o,
  input wire               data_lines_oe_o
);
  wire       sel = !select_low_active_n_o && select_high_active_o;
  reg [10:0] up_q;
  // age since reset, saturating once past the wait to stay small
  always @(posedge mclk_i or posedge rst_i)
    if (rst_i) up_q <= 11'h000;
    else if (!up_q[10]) up_q <= up_q + 11'h001;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ****************
  // pin rules
  // ****************
  sequence pulse_s; !write_strobe_n_o && sel && data_lines_oe_o; endsequence
  sequence end_s; write_strobe_n_o && sel && $stable(data_lines_o); endsequence
  a_write_steps: assert property (
    $fell(write_strobe_n_o) |-> pulse_s ##1 end_s) else $error("write steps");
  a_no_contention: assert property (
    !out_enable_n_o |-> !data_lines_oe_o) else $error("bus contention");
  a_power_wait: assert property (
    sel |-> up_q >= `POWER_UP_CYC) else $error("access too early");
  a_read_strobe: assert property (
    sel && !out_enable_n_o |-> write_strobe_n_o) else $error("strobe in read");
  a_addr_held: assert property (
    sel && $past(sel) |-> $stable(address_lines_o)) else $error("addr moved");
  a_strobe_framed: assert property (
    !write_strobe_n_o |-> sel && out_enable_n_o) else $error("bare strobe");
  a_data_hold: assert property (
    $fell(data_lines_oe_o) |-> write_strobe_n_o && $past(write_strobe_n_o))
    else $error("data not held");
endmodule
bind sram_host sram_host_chk i_chk (.*);

// ---- sram_host_map.vh ----
/*
  Constants for the asynchronous static RAM host controller: timing figures
  of the RAM, cycle counts derived from the 10 MHz clock, and bus widths.
  Assumes it is included by bare name into the controller, its checker and
  its bench, so that all three share one set of counts.
*/
`ifndef SRAM_HOST_MAP_VH
`define SRAM_HOST_MAP_VH

// ***************************************************
// clock and widths
// ***************************************************
`define CLK_PERIOD_NS      100
`define ADDR_W             17
`define DATA_W             8

// ***************************************************
// memory timing, in its own unit
// ***************************************************
`define POWER_UP_WAIT_US   100
`define WRITE_CYCLE_NS     10
`define WRITE_PULSE_NS     7
`define DATA_SETUP_NS      6
`define FLOAT_DELAY_NS     5
`define READ_CYCLE_NS      10
`define ADDR_TO_DATA_NS    10

// ***************************************************
// derived cycle counts (least times round up, never below one)
// ***************************************************
`define CEIL_CYC(t)  ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                      (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define POWER_UP_CYC  (((`POWER_UP_WAIT_US * 1000) + `CLK_PERIOD_NS - 1) / \
                       `CLK_PERIOD_NS)
`define STROBE_CYC    `CEIL_CYC(`WRITE_PULSE_NS + `FLOAT_DELAY_NS + \
                                `DATA_SETUP_NS)
`define READ_CYC      `CEIL_CYC(`ADDR_TO_DATA_NS + `READ_CYCLE_NS)
`define CNT_W         16
`define CNT_ZERO      16'h0000
`define CNT_ONE       16'h0001
`define ADDR_RST      17'h00000
`define DATA_RST      8'h00

`endif

// ---- sram_model.sv ----
/* Behavioural async static RAM that also resolves the shared data wire.
   Assumes the host's split data pins are handed to it. */
`timescale 1ns/1ps
module sram_model (
  input  wire [16:0] addr_i,
  input  wire        sel_n_i,
  input  wire        sel_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  input  wire [7:0]  hd_i,
  input  wire        hoe_i,
  output wire [7:0]  dq_o
);
  reg [7:0] mem [0:131071];
  reg [7:0] pat_q = 8'h00;
  wire      on  = !sel_n_i && sel_i;
  wire      drv = on && !oe_n_i && we_n_i;
  // a floating wire keeps moving so a stale value cannot pass as data
  always #37 pat_q = pat_q + 8'h5B;
  // store only inside the three-way overlap; leaving it ends the write
  always @* if (on && !we_n_i) mem[addr_i] = dq_o;
  assign dq_o = hoe_i ? hd_i : drv ? mem[addr_i] : pat_q;
endmodule
